// ---- logic/fast_timer.sv ----
// fast timer prescale, 10-bit register access and timebase crossing
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - all-zero prescale select stops the timer
// - codes 1 to 15 divide by powers of two
// - async mode uses fast timebase, sync uses system
// - ten bit counter and compares, eight bit if high zero
// - low byte read copies high bits to buffer
// - low byte write takes high bits from buffer
// - top value clears the counter on match
// - compares a, b, d drive pins and flags
// - five masked interrupt sources
// - control and compare registers read back immediately
// - counter and flags read back with sync lag
// - written values pass sync stages before use
// - bottom signalled when counter becomes zero
// - 0x3ff is the maximum count
// - top resets to 0x0ff
// - low speed halving halves the fast timebase
// - prescaler reset strobe clears divider, reads zero
// - fast timebase enable selects asynchronous mode
module fast_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic fast_tick,
	input wire logic fault_in,
	output logic compare_out_a,
	output logic compare_out_b,
	output logic compare_out_d,
	output logic bottom,
	output logic at_max,
	output logic irq
);
	localparam int CFG_W = 58;
	localparam int BACK_W = 14;

	logic waitrequest_reg, irq_reg, bottom_reg, at_max_reg;
	logic [31:0] readdata_reg;
	logic [7:0] ctrl_a_reg, ctrl_b_reg, ctrl_c_reg, ctrl_d_reg, ctrl_e_reg;
	logic [7:0] flags_reg, mask_reg, clkctl_reg;
	logic [9:0] cmp_a_reg, cmp_b_reg, top_reg, cmp_d_reg, cnt_val_reg;
	logic [1:0] hbuf_reg;
	logic cnt_wr_reg, psr_reg, fault_prev_reg;
	logic [9:0] cnt_reg;
	logic blk_reg, half_reg, ev_ovf_reg, ev_a_reg, ev_b_reg, ev_d_reg;
	logic out_a_reg, out_b_reg, out_d_reg;
	logic [CFG_W-1:0] cfg_d, cfg_q;
	logic [BACK_W-1:0] back_d, back_q;
	logic rd_acc, wr_acc, wrap;
	logic [7:0] wd;
	logic [7:0] rd_mux;
	logic [3:0] s_sel;
	logic [9:0] s_top, s_a, s_b, s_d, s_cval, r_cnt;
	logic s_async, s_lsm, s_psr, s_cwr;
	logic r_ovf, r_a, r_b, r_d;
	presc_if pif ();

	// ----------------------------------------------------------------
	// avalon slave handshake
	// ----------------------------------------------------------------
	assign rd_acc = read && !waitrequest_reg;
	assign wr_acc = write && !waitrequest_reg && byteenable[0];
	assign wd = writedata[7:0];

	// one wait cycle, then accept; back to waiting after each accept
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waitrequest_reg <= 1'b1;
		end else if (clk_en) begin
			waitrequest_reg <= !((read || write) && waitrequest_reg);
		end
	end

	// read multiplexer, low byte of every register
	always_comb begin
		rd_mux = 8'h00;
		case (address)
			fast_timer_pkg::OFF_CTRL_A: rd_mux = ctrl_a_reg;
			fast_timer_pkg::OFF_CTRL_B: rd_mux = ctrl_b_reg;
			fast_timer_pkg::OFF_CTRL_C: rd_mux = ctrl_c_reg;
			fast_timer_pkg::OFF_CTRL_D: rd_mux = ctrl_d_reg;
			fast_timer_pkg::OFF_CTRL_E: rd_mux = ctrl_e_reg;
			fast_timer_pkg::OFF_COUNT: rd_mux = r_cnt[7:0];
			fast_timer_pkg::OFF_CMP_A: rd_mux = cmp_a_reg[7:0];
			fast_timer_pkg::OFF_CMP_B: rd_mux = cmp_b_reg[7:0];
			fast_timer_pkg::OFF_TOP: rd_mux = top_reg[7:0];
			fast_timer_pkg::OFF_CMP_D: rd_mux = cmp_d_reg[7:0];
			fast_timer_pkg::OFF_HBUF: rd_mux = {6'h00, hbuf_reg};
			fast_timer_pkg::OFF_FLAGS: rd_mux = flags_reg;
			fast_timer_pkg::OFF_MASK: rd_mux = mask_reg;
			fast_timer_pkg::OFF_CLKCTL: rd_mux = clkctl_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	// read data captured in the wait cycle, held through the accept
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readdata_reg <= 32'h0000_0000;
		end else if (clk_en && read && waitrequest_reg) begin
			readdata_reg <= {24'h00_0000, rd_mux};
		end
	end

	// ----------------------------------------------------------------
	// cpu side register file
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_a_reg <= 8'h00;
			ctrl_b_reg <= 8'h00;
			ctrl_c_reg <= 8'h00;
			ctrl_e_reg <= 8'h00;
			mask_reg <= 8'h00;
			clkctl_reg <= 8'h00;
			cmp_a_reg <= 10'h000;
			cmp_b_reg <= 10'h000;
			top_reg <= fast_timer_pkg::TOP_RESET;
			cmp_d_reg <= 10'h000;
		end else if (clk_en && wr_acc) begin
			case (address)
				fast_timer_pkg::OFF_CTRL_A: ctrl_a_reg <= wd;
				fast_timer_pkg::OFF_CTRL_B:
					ctrl_b_reg <= wd & fast_timer_pkg::CTRL_B_RW;
				fast_timer_pkg::OFF_CTRL_C: ctrl_c_reg <= wd;
				fast_timer_pkg::OFF_CTRL_E: ctrl_e_reg <= wd;
				fast_timer_pkg::OFF_CMP_A: cmp_a_reg <= {hbuf_reg, wd};
				fast_timer_pkg::OFF_CMP_B: cmp_b_reg <= {hbuf_reg, wd};
				fast_timer_pkg::OFF_TOP: top_reg <= {hbuf_reg, wd};
				fast_timer_pkg::OFF_CMP_D: cmp_d_reg <= {hbuf_reg, wd};
				fast_timer_pkg::OFF_MASK:
					mask_reg <= wd & fast_timer_pkg::FLAG_BITS;
				fast_timer_pkg::OFF_CLKCTL:
					clkctl_reg <= wd & fast_timer_pkg::CLKCTL_RW;
				default: ;
			endcase
		end
	end

	// shared high byte buffer, loaded by writes and by low byte reads
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hbuf_reg <= 2'h0;
		end else if (clk_en) begin
			if (wr_acc && address == fast_timer_pkg::OFF_HBUF) begin
				hbuf_reg <= wd[1:0];
			end else if (rd_acc) begin
				case (address)
					fast_timer_pkg::OFF_COUNT: hbuf_reg <= r_cnt[9:8];
					fast_timer_pkg::OFF_CMP_A: hbuf_reg <= cmp_a_reg[9:8];
					fast_timer_pkg::OFF_CMP_B: hbuf_reg <= cmp_b_reg[9:8];
					fast_timer_pkg::OFF_TOP: hbuf_reg <= top_reg[9:8];
					fast_timer_pkg::OFF_CMP_D: hbuf_reg <= cmp_d_reg[9:8];
					default: ;
				endcase
			end
		end
	end

	// one-cycle strobes toward the timer side: counter load, prescaler clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_wr_reg <= 1'b0;
			cnt_val_reg <= 10'h000;
			psr_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_wr_reg <= wr_acc && address == fast_timer_pkg::OFF_COUNT;
			psr_reg <= wr_acc && address == fast_timer_pkg::OFF_CTRL_B &&
				wd[fast_timer_pkg::B_PSR];
			if (wr_acc && address == fast_timer_pkg::OFF_COUNT) begin
				cnt_val_reg <= {hbuf_reg, wd};
			end
		end
	end

	// ----------------------------------------------------------------
	// flags: hardware set beats write-one clear
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags_reg <= 8'h00;
			ctrl_d_reg <= 8'h00;
			fault_prev_reg <= 1'b0;
		end else if (clk_en) begin
			fault_prev_reg <= fault_in;
			if (wr_acc && address == fast_timer_pkg::OFF_FLAGS) begin
				flags_reg <= flags_reg & ~(wd & fast_timer_pkg::FLAG_BITS);
			end
			if (r_ovf) flags_reg[fast_timer_pkg::B_FLAG_OVF] <= 1'b1;
			if (r_a) flags_reg[fast_timer_pkg::B_FLAG_A] <= 1'b1;
			if (r_b) flags_reg[fast_timer_pkg::B_FLAG_B] <= 1'b1;
			if (r_d) flags_reg[fast_timer_pkg::B_FLAG_D] <= 1'b1;
			if (wr_acc && address == fast_timer_pkg::OFF_CTRL_D) begin
				ctrl_d_reg <= {wd[7:3],
					ctrl_d_reg[fast_timer_pkg::B_FPF] & ~wd[fast_timer_pkg::B_FPF],
					wd[1:0]};
			end
			if (fault_in && !fault_prev_reg) begin
				ctrl_d_reg[fast_timer_pkg::B_FPF] <= 1'b1;
			end
		end
	end

	// single request line from all masked sources
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else if (clk_en) begin
			irq_reg <= (|(flags_reg & mask_reg)) ||
				(ctrl_d_reg[fast_timer_pkg::B_FPF] &&
				ctrl_d_reg[fast_timer_pkg::B_FPIE]);
		end
	end

	// ----------------------------------------------------------------
	// crossing into the timer side and back
	// ----------------------------------------------------------------
	assign cfg_d = {ctrl_b_reg[3:0], top_reg, cmp_a_reg, cmp_b_reg, cmp_d_reg,
		clkctl_reg[fast_timer_pkg::B_FTE], clkctl_reg[fast_timer_pkg::B_LSM],
		psr_reg, cnt_wr_reg, cnt_val_reg};
	assign {s_sel, s_top, s_a, s_b, s_d, s_async, s_lsm, s_psr, s_cwr,
		s_cval} = cfg_q;

	stage_sync #(.W(CFG_W), .STAGES(fast_timer_pkg::SYNC_STAGES)) u_in_sync (
		.clk(ref_clk),
		.rst(rst),
		.ce(clk_en),
		.d(cfg_d),
		.q(cfg_q)
	);

	assign back_d = {ev_ovf_reg, ev_a_reg, ev_b_reg, ev_d_reg, cnt_reg};
	assign {r_ovf, r_a, r_b, r_d, r_cnt} = back_q;

	stage_sync #(.W(BACK_W), .STAGES(fast_timer_pkg::SYNC_STAGES)) u_out_sync (
		.clk(ref_clk),
		.rst(rst),
		.ce(clk_en),
		.d(back_d),
		.q(back_q)
	);

	// ----------------------------------------------------------------
	// timebase select and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			half_reg <= 1'b0;
		end else if (clk_en && fast_tick) begin
			half_reg <= !half_reg;
		end
	end

	assign pif.sel = s_sel;
	assign pif.clear = s_psr;
	assign pif.base_tick = s_async ? (fast_tick && (!s_lsm || half_reg)) :
		1'b1;

	prescale_div #(.DIV_BITS(fast_timer_pkg::DIV_BITS)) u_div (
		.clk(ref_clk),
		.rst(rst),
		.ce(clk_en),
		.p(pif.divider)
	);

	// ----------------------------------------------------------------
	// counter and compare units
	// ----------------------------------------------------------------
	assign wrap = cnt_reg == s_top || cnt_reg == fast_timer_pkg::COUNT_MAX;

	// cpu load has priority, top match or max clears, else count up
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 10'h000;
			blk_reg <= 1'b0;
		end else if (clk_en) begin
			if (s_cwr) begin
				cnt_reg <= s_cval;
				blk_reg <= 1'b1;
			end else if (pif.count_tick) begin
				blk_reg <= 1'b0;
				cnt_reg <= wrap ? fast_timer_pkg::COUNT_BOTTOM :
					cnt_reg + 10'h001;
			end
		end
	end

	// match events one tick after equality; a, b, d blocked after a load, overflow not
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ev_ovf_reg <= 1'b0;
			ev_a_reg <= 1'b0;
			ev_b_reg <= 1'b0;
			ev_d_reg <= 1'b0;
		end else if (clk_en) begin
			ev_ovf_reg <= pif.count_tick && !s_cwr && wrap;
			ev_a_reg <= pif.count_tick && !s_cwr && !blk_reg &&
				cnt_reg == s_a;
			ev_b_reg <= pif.count_tick && !s_cwr && !blk_reg &&
				cnt_reg == s_b;
			ev_d_reg <= pif.count_tick && !s_cwr && !blk_reg &&
				cnt_reg == s_d;
		end
	end

	// output pins toggle on each match
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_a_reg <= 1'b0;
			out_b_reg <= 1'b0;
			out_d_reg <= 1'b0;
		end else if (clk_en) begin
			if (ev_a_reg) out_a_reg <= !out_a_reg;
			if (ev_b_reg) out_b_reg <= !out_b_reg;
			if (ev_d_reg) out_d_reg <= !out_d_reg;
		end
	end

	// bottom and max status levels
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bottom_reg <= 1'b0;
			at_max_reg <= 1'b0;
		end else if (clk_en) begin
			bottom_reg <= cnt_reg == fast_timer_pkg::COUNT_BOTTOM;
			at_max_reg <= cnt_reg == fast_timer_pkg::COUNT_MAX;
		end
	end

	assign readdata = readdata_reg;
	assign waitrequest = waitrequest_reg;
	assign irq = irq_reg;
	assign compare_out_a = out_a_reg;
	assign compare_out_b = out_b_reg;
	assign compare_out_d = out_d_reg;
	assign bottom = bottom_reg;
	assign at_max = at_max_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_sync_base: assert property (!s_async |-> pif.base_tick)
		else $error("sync mode lost the system timebase");
	a_top_default: assert property ($past(rst) |-> top_reg == 10'h0ff)
		else $error("top not at default after reset");
	a_low_copy: assert property ((clk_en && rd_acc &&
		address == fast_timer_pkg::OFF_CMP_A) |=>
		hbuf_reg == $past(cmp_a_reg[9:8]))
		else $error("low byte read did not load buffer");
	a_low_write: assert property ((clk_en && wr_acc &&
		address == fast_timer_pkg::OFF_CMP_A) |=>
		cmp_a_reg == {$past(hbuf_reg), $past(wd)})
		else $error("low byte write missed buffer bits");
	a_top_clear: assert property ((clk_en && pif.count_tick && !s_cwr &&
		cnt_reg == s_top) |=> cnt_reg == 10'h000)
		else $error("counter not cleared at top");
	a_ctrl_readback: assert property ((clk_en && wr_acc &&
		address == fast_timer_pkg::OFF_CTRL_B) |=>
		ctrl_b_reg[3:0] == $past(wd[3:0]) && !ctrl_b_reg[6])
		else $error("control b readback wrong");
	a_psr_path: assert property ((clk_en && psr_reg) ##1 clk_en[*2]
		|-> pif.clear)
		else $error("prescaler clear did not pass the sync stages");
	a_bottom_flag: assert property ((clk_en && cnt_reg == 10'h000) |=>
		bottom_reg)
		else $error("bottom not signalled at zero");
	a_max_wrap: assert property ((clk_en && pif.count_tick && !s_cwr &&
		cnt_reg == 10'h3ff) |=> cnt_reg == 10'h000)
		else $error("counter passed max");
endmodule

// ---- logic/fast_timer_pkg.sv ----
// constants shared by the fast timer prescale and register access logic
package fast_timer_pkg;
	// ----------------------------------------------------------------
	// register byte offsets on the avalon slave
	// ----------------------------------------------------------------
	localparam logic [5:0] OFF_CTRL_A = 6'h00;
	localparam logic [5:0] OFF_CTRL_B = 6'h04;
	localparam logic [5:0] OFF_CTRL_C = 6'h08;
	localparam logic [5:0] OFF_CTRL_D = 6'h0c;
	localparam logic [5:0] OFF_CTRL_E = 6'h10;
	localparam logic [5:0] OFF_COUNT = 6'h14;
	localparam logic [5:0] OFF_CMP_A = 6'h18;
	localparam logic [5:0] OFF_CMP_B = 6'h1c;
	localparam logic [5:0] OFF_TOP = 6'h20;
	localparam logic [5:0] OFF_CMP_D = 6'h24;
	localparam logic [5:0] OFF_HBUF = 6'h28;
	localparam logic [5:0] OFF_FLAGS = 6'h2c;
	localparam logic [5:0] OFF_MASK = 6'h30;
	localparam logic [5:0] OFF_CLKCTL = 6'h34;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B_PSR = 6; // prescaler reset strobe in control b
	localparam int B_FPIE = 7; // fault irq enable in control d
	localparam int B_FPF = 2; // fault protect flag in control d
	localparam int B_FLAG_D = 7;
	localparam int B_FLAG_A = 6;
	localparam int B_FLAG_B = 5;
	localparam int B_FLAG_OVF = 2;
	localparam int B_LSM = 7; // low speed halving in clock control
	localparam int B_FTE = 2; // fast timebase enable in clock control
	localparam logic [7:0] CTRL_B_RW = 8'h3f; // bit 7 reserved, 6 strobe
	localparam logic [7:0] FLAG_BITS = 8'he4;
	localparam logic [7:0] CLKCTL_RW = 8'h84;
	// ----------------------------------------------------------------
	// reset values, limits and timing
	// ----------------------------------------------------------------
	localparam logic [9:0] TOP_RESET = 10'h0ff;
	localparam logic [9:0] COUNT_MAX = 10'h3ff;
	localparam logic [9:0] COUNT_BOTTOM = 10'h000;
	localparam logic [3:0] SEL_STOP = 4'h0;
	localparam int SYNC_STAGES = 2;
	localparam int DIV_BITS = 14;
endpackage

// ---- logic/presc_if.sv ----
// link between the timer core and its prescale divider
`timescale 1ns/1ps
interface presc_if;
	logic [3:0] sel;
	logic clear;
	logic base_tick;
	logic count_tick;
	modport ctrl(output sel, output clear, output base_tick,
		input count_tick);
	modport divider(input sel, input clear, input base_tick,
		output count_tick);
endinterface

// ---- logic/stage_sync.sv ----
// multi stage pipeline carrying words between the cpu and timer sides
`timescale 1ns/1ps
module stage_sync #(
	parameter int W = 8,
	parameter int STAGES = fast_timer_pkg::SYNC_STAGES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage_reg [STAGES];

	// ----------------------------------------------------------------
	// shift chain, each stage only feeds the next
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= '0;
			end
		end else if (ce) begin
			stage_reg[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage_reg[i] <= stage_reg[i-1];
			end
		end
	end

	assign q = stage_reg[STAGES-1];
endmodule

// ---- logic/prescale_div.sv ----
// free running divider with tap select for the count enable
`timescale 1ns/1ps
module prescale_div #(
	parameter int DIV_BITS = fast_timer_pkg::DIV_BITS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	presc_if.divider p
);
	logic [DIV_BITS-1:0] div_reg;

	// true when the divider sits on the last step of a 2^(sel-1) period
	function automatic logic tap_hit(input logic [3:0] sel,
		input logic [DIV_BITS-1:0] div);
		logic [DIV_BITS-1:0] m;
		m = '0;
		for (int i = 0; i < DIV_BITS; i++) begin
			if (i + 1 < int'(sel)) m[i] = 1'b1;
		end
		return (div & m) == m;
	endfunction

	// ----------------------------------------------------------------
	// divider advances on every selected timebase tick
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else if (ce) begin
			if (p.clear) begin
				div_reg <= '0;
			end else if (p.base_tick) begin
				div_reg <= div_reg + 1'b1;
			end
		end
	end

	// stop code gives no ticks, others gate the matching tap
	assign p.count_tick = (p.sel != fast_timer_pkg::SEL_STOP) &&
		p.base_tick && !p.clear && tap_hit(p.sel, div_reg);

	a_stop_no_tick: assert property (@(posedge clk) disable iff (rst)
		p.sel == fast_timer_pkg::SEL_STOP |-> !p.count_tick)
		else $error("tick while prescaler stopped");
	a_div_two: assert property (@(posedge clk) disable iff (rst)
		(ce && p.sel == 4'h2 && p.count_tick) |=> !p.count_tick)
		else $error("divide by two ticked twice in a row");
endmodule

// ---- testbench/tb_fast_timer.sv ----
// self-checking bench for the fast timer prescale and register access
`timescale 1ns/1ps
module tb_fast_timer;
	typedef struct {
		logic [5:0] a;
		logic [1:0] h;
		logic [7:0] d;
		logic [7:0] e;
		logic w;
	} row_t;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic fast_tick = 1'b0;
	logic fault_in = 1'b0;
	logic compare_out_a, compare_out_b, compare_out_d, bottom, at_max, irq;
	logic pa = 1'b0, pb = 1'b0, pd = 1'b0;
	logic [7:0] v, hi;
	int n_mismatch = 0, compares = 0, n_cyc = 0, n_ft = 0;
	int n_a = 0, n_b = 0, n_d = 0, n_bot = 0, n_max = 0;
	int sa, sb, sd, sbot, c0, n;
	row_t rows[10];

	fast_timer uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.fast_tick(fast_tick), .fault_in(fault_in),
		.compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
		.compare_out_d(compare_out_d), .bottom(bottom), .at_max(at_max),
		.irq(irq));

	always #5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// monitors, fast strobe and timeout
	// ------------------------------------------------------------
	// fast strobe every third cycle keeps it well under half rate
	always @(posedge ref_clk) begin
		n_cyc <= n_cyc + 1;
		n_ft <= (n_ft == 2) ? 0 : n_ft + 1;
		fast_tick <= (n_ft == 2);
		pa <= compare_out_a;
		pb <= compare_out_b;
		pd <= compare_out_d;
		if (compare_out_a !== pa) n_a <= n_a + 1;
		if (compare_out_b !== pb) n_b <= n_b + 1;
		if (compare_out_d !== pd) n_d <= n_d + 1;
		if (bottom === 1'b1) n_bot <= n_bot + 1;
		if (at_max === 1'b1) n_max <= n_max + 1;
		if (n_cyc == 100000) begin
			n_mismatch++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// bus tasks and comparison
	// ------------------------------------------------------------
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// hold the request until waitrequest is sampled low
	task automatic wait_ack();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k == 50) chk(1'b0, 1'b1);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] be = 4'hf);
		@(posedge ref_clk);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		write <= 1'b1;
		wait_ack();
		write <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		address <= a;
		read <= 1'b1;
		wait_ack();
		d = readdata[7:0];
		read <= 1'b0;
	endtask

	// count ticks seen by the counter over w cycles between accepts
	task automatic meas(input logic [7:0] sel, input int w, output int c);
		logic [7:0] r;
		wr(fast_timer_pkg::OFF_HBUF, 8'h00);
		wr(fast_timer_pkg::OFF_COUNT, 8'h00);
		repeat (8) @(posedge ref_clk);
		wr(fast_timer_pkg::OFF_CTRL_B, sel);
		repeat (w - 3) @(posedge ref_clk);
		wr(fast_timer_pkg::OFF_CTRL_B, 8'h00);
		repeat (8) @(posedge ref_clk);
		rd(fast_timer_pkg::OFF_COUNT, r);
		c = int'(r);
	endtask

	task automatic close_out();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rows = '{
			'{fast_timer_pkg::OFF_CTRL_A, 2'h0, 8'h5a, 8'h5a, 1'b0},
			'{fast_timer_pkg::OFF_CTRL_B, 2'h0, 8'hff, 8'h3f, 1'b0},
			'{fast_timer_pkg::OFF_CTRL_C, 2'h0, 8'ha5, 8'ha5, 1'b0},
			'{fast_timer_pkg::OFF_CTRL_D, 2'h0, 8'h80, 8'h80, 1'b0},
			'{fast_timer_pkg::OFF_CMP_A, 2'h3, 8'h12, 8'h12, 1'b1},
			'{fast_timer_pkg::OFF_CMP_B, 2'h1, 8'h34, 8'h34, 1'b1},
			'{fast_timer_pkg::OFF_TOP, 2'h2, 8'hc3, 8'hc3, 1'b1},
			'{fast_timer_pkg::OFF_CMP_D, 2'h3, 8'h56, 8'h56, 1'b1},
			'{fast_timer_pkg::OFF_CLKCTL, 2'h0, 8'hff, 8'h84, 1'b0},
			'{6'h38, 2'h0, 8'haa, 8'h00, 1'b0}
		};
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		// write, clear the buffer, read back low byte and copied high bits
		foreach (rows[i]) begin
			wr(fast_timer_pkg::OFF_HBUF, {6'h0, rows[i].h});
			wr(rows[i].a, rows[i].d);
			if (rows[i].w) wr(fast_timer_pkg::OFF_HBUF, 8'h00);
			rd(rows[i].a, v);
			chk({2'h0, v}, {2'h0, rows[i].e});
			if (rows[i].w) begin
				repeat (4) @(posedge ref_clk);
				rd(fast_timer_pkg::OFF_HBUF, v);
				chk({2'h0, v}, {8'h0, rows[i].h});
			end
		end
		// reset in mid-run brings back idle outputs and default top
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(waitrequest, 1'b1);
		chk(irq, 1'b0);
		chk(compare_out_a, 1'b0);
		rst <= 1'b0;
		rd(fast_timer_pkg::OFF_TOP, v);
		repeat (4) @(posedge ref_clk);
		rd(fast_timer_pkg::OFF_HBUF, hi);
		chk({hi[1:0], v}, fast_timer_pkg::TOP_RESET);
		// all-zero select leaves the counter where it was written
		wr(fast_timer_pkg::OFF_COUNT, 8'h05);
		repeat (50) @(posedge ref_clk);
		rd(fast_timer_pkg::OFF_COUNT, v);
		chk({2'h0, v}, 10'h005);
		// every non-zero select code, divider realigned by the reset strobe
		wr(fast_timer_pkg::OFF_HBUF, 8'h03);
		wr(fast_timer_pkg::OFF_TOP, 8'hff);
		for (int k = 1; k < 16; k++) begin
			n = (k < 14) ? 4 : 2;
			meas(8'h40 | 8'(k), n << (k - 1), c0);
			chk(c0 >= n - 1 && c0 <= n + 1, 1'b1);
		end
		// fast timebase, then halved
		wr(fast_timer_pkg::OFF_CLKCTL, 8'h04);
		meas(8'h41, 300, c0);
		chk(c0 >= 98 && c0 <= 102, 1'b1);
		wr(fast_timer_pkg::OFF_CLKCTL, 8'h84);
		meas(8'h41, 300, c0);
		chk(c0 >= 48 && c0 <= 52, 1'b1);
		wr(fast_timer_pkg::OFF_CLKCTL, 8'h00);
		// short top with three compares inside the period
		wr(fast_timer_pkg::OFF_HBUF, 8'h00);
		wr(fast_timer_pkg::OFF_TOP, 8'h05);
		wr(fast_timer_pkg::OFF_CMP_A, 8'h03);
		wr(fast_timer_pkg::OFF_CMP_B, 8'h02);
		wr(fast_timer_pkg::OFF_CMP_D, 8'h04);
		wr(fast_timer_pkg::OFF_COUNT, 8'h00);
		wr(fast_timer_pkg::OFF_MASK, 8'h04);
		wr(fast_timer_pkg::OFF_CTRL_B, 8'h41);
		// skip the start-up stretch at zero, then count a steady window
		repeat (8) @(posedge ref_clk);
		sa = n_a;
		sb = n_b;
		sd = n_d;
		sbot = n_bot;
		repeat (60) @(posedge ref_clk);
		chk((n_a - sa) inside {[8:12]}, 1'b1);
		chk((n_b - sb) inside {[8:12]}, 1'b1);
		chk((n_d - sd) inside {[8:12]}, 1'b1);
		chk((n_bot - sbot) inside {[8:12]}, 1'b1);
		repeat (4) begin
			rd(fast_timer_pkg::OFF_COUNT, v);
			chk(v <= 8'h05, 1'b1);
		end
		chk(irq, 1'b1);
		rd(fast_timer_pkg::OFF_FLAGS, v);
		chk(v & fast_timer_pkg::FLAG_BITS, fast_timer_pkg::FLAG_BITS);
		// stop, clear flags by writing ones, then raise a fault
		wr(fast_timer_pkg::OFF_CTRL_B, 8'h00);
		repeat (8) @(posedge ref_clk);
		wr(fast_timer_pkg::OFF_FLAGS, 8'he4);
		repeat (8) @(posedge ref_clk);
		rd(fast_timer_pkg::OFF_FLAGS, v);
		chk({2'h0, v}, 10'h000);
		chk(irq, 1'b0);
		wr(fast_timer_pkg::OFF_CTRL_D, 8'h80);
		fault_in <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk(irq, 1'b1);
		rd(fast_timer_pkg::OFF_CTRL_D, v);
		chk(v[fast_timer_pkg::B_FPF], 1'b1);
		fault_in <= 1'b0;
		wr(fast_timer_pkg::OFF_CTRL_D, 8'h84);
		repeat (8) @(posedge ref_clk);
		chk(irq, 1'b0);
		// low byte lane disabled: write dropped
		wr(fast_timer_pkg::OFF_CMP_A, 8'h77, 4'he);
		rd(fast_timer_pkg::OFF_CMP_A, v);
		chk({2'h0, v}, 10'h003);
		// run through 0x3ff with the widest top
		wr(fast_timer_pkg::OFF_HBUF, 8'h03);
		wr(fast_timer_pkg::OFF_TOP, 8'hff);
		wr(fast_timer_pkg::OFF_COUNT, 8'hfa);
		// let the load land so an old zero is not counted as bottom
		repeat (6) @(posedge ref_clk);
		sa = n_max;
		sbot = n_bot;
		wr(fast_timer_pkg::OFF_CTRL_B, 8'h41);
		repeat (30) @(posedge ref_clk);
		chk(n_max - sa, 10'd1);
		chk(n_bot - sbot, 10'd1);
		rd(fast_timer_pkg::OFF_FLAGS, v);
		chk(v[fast_timer_pkg::B_FLAG_OVF], 1'b1);
		close_out();
	end
endmodule
